// ---- src/status_query_pkg.sv ----
package status_query_pkg;
	localparam logic [7:0] OP_RX_BUFFER_QUERY = 8'h17;
	localparam logic [7:0] OP_PACKET_INFO_QUERY = 8'h1D;
	localparam logic [7:0] UART_LEN_RX_BUFFER = 8'h02;
	localparam logic [7:0] UART_LEN_PACKET_INFO = 8'h05;
	localparam logic [11:0] ADDR_IMPLICIT_SIZE = 12'h901;
	localparam logic [7:0] IMPLICIT_LENGTH = 8'h00;
	localparam logic [2:0] SPI_PAD_RX_BUFFER = 3'h3;
	localparam logic [2:0] SPI_PAD_PACKET_INFO = 3'h6;
	localparam logic [2:0] CHIRP_INFO_BYTES = 3'h2;
	localparam logic [2:0] FSK_INFO_BYTES = 3'h5;
	localparam logic [2:0] SPI_STATUS_BYTES = 3'h2;
	localparam logic [2:0] RX_BUFFER_BYTES = 3'h2;
	localparam int XFER_ACK_SUPPRESS_BIT = 5;
	localparam int XFER_TX_COMPLETE_BIT = 0;
	localparam int ERR_SYNC_FAIL_BIT = 6;
	localparam int ERR_OVERSIZE_BIT = 5;
	localparam int ERR_CHECKSUM_BIT = 4;
	localparam int ERR_ABORTED_BIT = 3;
	localparam int ERR_HEADER_SEEN_BIT = 2;
	localparam int ERR_RX_COMPLETE_BIT = 1;
	localparam int ERR_ENGINE_ACTIVE_BIT = 0;
	localparam logic [7:0] FLAGS_RESET = 8'h00;

	typedef enum logic [1:0] {
		PKT_FSK = 2'b00,
		PKT_BLE = 2'b01,
		PKT_CODED_FSK = 2'b10,
		PKT_CHIRP = 2'b11
	} packet_type_t;

	// snapshot of the packet engine presented to the responder
	typedef struct packed {
		logic ack_suppress_field;
		logic tx_complete_flag;
		logic sync_detect_fail_flag;
		logic oversize_flag;
		logic checksum_fail_flag;
		logic aborted_flag;
		logic header_seen_flag;
		logic rx_complete_flag;
		logic packet_engine_active;
		logic [2:0] matched_sync_code;
		logic [7:0] sync_latched_power;
		logic [7:0] snr_quarter_db;
	} engine_status_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_UART_LEN = 2'b01,
		ST_SEND = 2'b10
	} query_state_t;
endpackage : status_query_pkg

// ---- src/rx_status_query_responder.sv ----
// Notes on behaviour
// - spi buffer query: two status, length, offset
// - start offset counted from buffer start
// - uart buffer query: length byte two, two bytes
// - chirp implicit header reports length zero
// - implicit size readable at register 0x901
// - spi info query: two status, five bytes
// - uart info query: length five, no status
// - chirp alone returns two bytes only
// - fsk types return five bytes in order
// - power latched at sync detect, minus half dbm
// - snr is two's complement quarter db
// - ack suppress field in transfer bit five
// - transfer bit zero marks tx complete
// - error bit six gives sync detect outcome
// - error bit five marks oversize packet
// - error bit four gives checksum result
// - error bit three marks aborted packet
// - error bit two marks header received
// - error bit one marks rx complete
// - error bit zero while engine busy
// - sync code one-hot, zero means error
`timescale 1ns/1ns
`default_nettype none
module rx_status_query_responder (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// byte stream from the command framing
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic cmd_first,
	input wire logic uart_mode,
	// byte stream back to the host
	output logic rsp_valid,
	output logic [7:0] rsp_byte,
	output logic rsp_last,
	// chip status byte and register read port
	input wire logic [7:0] chip_status,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	output logic [7:0] reg_rdata,
	// packet engine view
	input wire status_query_pkg::packet_type_t packet_type,
	input wire logic implicit_header,
	input wire logic [7:0] implicit_size,
	input wire logic [7:0] last_received_size,
	input wire logic [7:0] rx_base_addr,
	input wire logic [7:0] first_byte_offset,
	input wire logic sync_detect,
	input wire logic [7:0] live_power,
	input wire status_query_pkg::engine_status_t eng,
	// decoded flag bytes, for observation
	output logic [7:0] packet_transfer_flags,
	output logic [7:0] packet_error_flags
);
	// release reaches the logic two clocks late, never close to a clock edge
	logic rst_meta_reg;
	logic rst_sync_reg;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	wire logic rst_n = rst_sync_reg;

	// power sampled on the sync-detect cycle, held until the next packet syncs
	logic [7:0] power_reg, power_next;
	always_comb begin
		power_next = sync_detect ? live_power : power_reg;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_reg <= status_query_pkg::FLAGS_RESET;
		end else begin
			power_reg <= power_next;
		end
	end

	// flag bytes as the host sees them; reserved positions read as zero
	logic [7:0] xfer_now, err_now, sync_now;
	always_comb begin
		xfer_now = status_query_pkg::FLAGS_RESET;
		xfer_now[status_query_pkg::XFER_ACK_SUPPRESS_BIT] = eng.ack_suppress_field;
		xfer_now[status_query_pkg::XFER_TX_COMPLETE_BIT] = eng.tx_complete_flag;
		err_now = status_query_pkg::FLAGS_RESET;
		err_now[status_query_pkg::ERR_SYNC_FAIL_BIT] = eng.sync_detect_fail_flag;
		err_now[status_query_pkg::ERR_OVERSIZE_BIT] = eng.oversize_flag;
		err_now[status_query_pkg::ERR_CHECKSUM_BIT] = eng.checksum_fail_flag;
		err_now[status_query_pkg::ERR_ABORTED_BIT] = eng.aborted_flag;
		err_now[status_query_pkg::ERR_HEADER_SEEN_BIT] = eng.header_seen_flag;
		err_now[status_query_pkg::ERR_RX_COMPLETE_BIT] = eng.rx_complete_flag;
		err_now[status_query_pkg::ERR_ENGINE_ACTIVE_BIT] = eng.packet_engine_active;
		sync_now = {5'h00, eng.matched_sync_code};
	end

	// registered copies so the observation outputs come straight from flops
	logic [7:0] xfer_reg, xfer_next;
	logic [7:0] err_reg, err_next;
	always_comb begin
		xfer_next = xfer_now;
		err_next = err_now;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			xfer_reg <= status_query_pkg::FLAGS_RESET;
			err_reg <= status_query_pkg::FLAGS_RESET;
		end else begin
			xfer_reg <= xfer_next;
			err_reg <= err_next;
		end
	end
	always_comb packet_transfer_flags = xfer_reg;
	always_comb packet_error_flags = err_reg;

	// the engine counts from the receive base; the host wants buffer-relative offsets
	logic [7:0] offset_now;
	always_comb offset_now = 8'(rx_base_addr + first_byte_offset);

	// a chirp packet without a header has no length to report
	logic [7:0] length_now;
	always_comb begin
		if (packet_type == status_query_pkg::PKT_CHIRP && implicit_header) begin
			length_now = status_query_pkg::IMPLICIT_LENGTH;
		end else begin
			length_now = last_received_size;
		end
	end

	// register read port: only the implicit payload size is mapped here
	logic [7:0] rdata_reg, rdata_next;
	always_comb begin
		rdata_next = rdata_reg;
		if (reg_rd) begin
			if (reg_addr == status_query_pkg::ADDR_IMPLICIT_SIZE) begin
				rdata_next = implicit_size;
			end else begin
				rdata_next = 8'h00;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end
	always_comb reg_rdata = rdata_reg;

	// opcode decode and the size of the answer for the query in hand
	logic op_rx_buffer, op_packet_info, start_cmd, info_kind;
	logic [2:0] payload_bytes, end_pos_now, last_pos;
	logic [7:0] uart_len_now;
	status_query_pkg::query_state_t state_reg, state_next;
	logic info_reg, info_next;
	logic [2:0] pos_reg, pos_next;
	logic [2:0] end_reg, end_next;
	always_comb begin
		op_rx_buffer = cmd_byte == status_query_pkg::OP_RX_BUFFER_QUERY;
		op_packet_info = cmd_byte == status_query_pkg::OP_PACKET_INFO_QUERY;
		start_cmd = cmd_valid && cmd_first && (op_rx_buffer || op_packet_info);
		info_kind = (state_reg == status_query_pkg::ST_IDLE) ? op_packet_info : info_reg;
		if (!info_kind) begin
			payload_bytes = status_query_pkg::RX_BUFFER_BYTES;
			uart_len_now = status_query_pkg::UART_LEN_RX_BUFFER;
		end else if (packet_type == status_query_pkg::PKT_CHIRP) begin
			payload_bytes = status_query_pkg::CHIRP_INFO_BYTES;
			uart_len_now = status_query_pkg::UART_LEN_PACKET_INFO;
		end else begin
			payload_bytes = status_query_pkg::FSK_INFO_BYTES;
			uart_len_now = status_query_pkg::UART_LEN_PACKET_INFO;
		end
		end_pos_now = 3'(status_query_pkg::SPI_STATUS_BYTES + payload_bytes);
		last_pos = 3'(end_reg - 3'h1);
	end

	// one query at a time; bytes arriving while an answer runs are padding
	always_comb begin
		state_next = state_reg;
		info_next = info_reg;
		pos_next = pos_reg;
		end_next = end_reg;
		case (state_reg)
			status_query_pkg::ST_IDLE: begin
				if (start_cmd) begin
					info_next = op_packet_info;
					end_next = end_pos_now;
					if (uart_mode) begin
						// the uart answer carries no status bytes, so it starts past them
						state_next = status_query_pkg::ST_UART_LEN;
						pos_next = status_query_pkg::SPI_STATUS_BYTES;
					end else begin
						state_next = status_query_pkg::ST_SEND;
						pos_next = 3'h0;
					end
				end
			end
			status_query_pkg::ST_UART_LEN: begin
				if (cmd_valid) begin
					// a wrong length byte drops the query rather than guessing
					if (cmd_byte == uart_len_now) begin
						state_next = status_query_pkg::ST_SEND;
					end else begin
						state_next = status_query_pkg::ST_IDLE;
					end
				end
			end
			status_query_pkg::ST_SEND: begin
				pos_next = 3'(pos_reg + 3'h1);
				if (pos_reg == last_pos) begin
					state_next = status_query_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = status_query_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= status_query_pkg::ST_IDLE;
			info_reg <= 1'b0;
			pos_reg <= 3'h0;
			end_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			info_reg <= info_next;
			pos_reg <= pos_next;
			end_reg <= end_next;
		end
	end

	// byte for the current answer position; status bytes lead on spi only
	logic [2:0] rel_pos;
	logic [7:0] byte_now;
	always_comb begin
		rel_pos = 3'(pos_reg - status_query_pkg::SPI_STATUS_BYTES);
		byte_now = 8'h00;
		if (pos_reg < status_query_pkg::SPI_STATUS_BYTES) begin
			byte_now = chip_status;
		end else if (!info_reg) begin
			byte_now = (rel_pos == 3'h0) ? length_now : offset_now;
		end else if (packet_type == status_query_pkg::PKT_CHIRP) begin
			// snr passes through untouched: it already is two's complement quarter db
			byte_now = (rel_pos == 3'h0) ? power_reg : eng.snr_quarter_db;
		end else begin
			case (rel_pos)
				3'h0: byte_now = 8'h00;
				3'h1: byte_now = power_reg;
				3'h2: byte_now = err_now;
				3'h3: byte_now = xfer_now;
				default: byte_now = sync_now;
			endcase
		end
	end

	// answer stream; every output leaves from a flop
	logic rsp_valid_reg, rsp_valid_next;
	logic [7:0] rsp_byte_reg, rsp_byte_next;
	logic rsp_last_reg, rsp_last_next;
	always_comb begin
		rsp_valid_next = state_reg == status_query_pkg::ST_SEND;
		rsp_byte_next = rsp_valid_next ? byte_now : 8'h00;
		rsp_last_next = rsp_valid_next && pos_reg == last_pos;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid_reg <= 1'b0;
			rsp_byte_reg <= 8'h00;
			rsp_last_reg <= 1'b0;
		end else begin
			rsp_valid_reg <= rsp_valid_next;
			rsp_byte_reg <= rsp_byte_next;
			rsp_last_reg <= rsp_last_next;
		end
	end
	always_comb rsp_valid = rsp_valid_reg;
	always_comb rsp_byte = rsp_byte_reg;
	always_comb rsp_last = rsp_last_reg;

	property p_spi_status_first;
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && start_cmd && !uart_mode && state_reg == status_query_pkg::ST_IDLE
			|-> ##2 (rsp_valid && rsp_byte == $past(chip_status));
	endproperty
	a_spi_status_first: assert property (p_spi_status_first) else $error("spi answer does not open with status");
	property p_uart_no_status;
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && start_cmd && uart_mode && state_reg == status_query_pkg::ST_IDLE |-> ##2 !rsp_valid;
	endproperty
	a_uart_no_status: assert property (p_uart_no_status) else $error("uart answer began before length byte");
	property p_last_in_stream;
		@(posedge ref_clk) disable iff (!rst_n)
		rsp_last |-> rsp_valid;
	endproperty
	a_last_in_stream: assert property (p_last_in_stream) else $error("last marker without a byte");
	property p_power_latch;
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && sync_detect |=> power_reg == $past(live_power);
	endproperty
	a_power_latch: assert property (p_power_latch) else $error("power not taken at sync detect");
	property p_power_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && !sync_detect |=> $stable(power_reg);
	endproperty
	a_power_hold: assert property (p_power_hold) else $error("latched power moved without sync detect");
	property p_error_byte;
		@(posedge ref_clk) disable iff (!rst_n)
		$past(rst_n) |-> packet_error_flags == $past(err_now);
	endproperty
	a_error_byte: assert property (p_error_byte) else $error("error byte does not follow the engine");
	property p_reserved_zero;
		@(posedge ref_clk) disable iff (!rst_n)
		packet_error_flags[7] == 1'b0 && packet_transfer_flags[7:6] == 2'b00 && packet_transfer_flags[4:1] == 4'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag bit set");
endmodule : rx_status_query_responder
`default_nettype wire

// ---- testbench/host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_model (
	// command stream to the responder
	input wire logic ref_clk,
	output logic cmd_valid,
	output logic [7:0] cmd_byte,
	output logic cmd_first,
	// answer stream
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_byte,
	input wire logic rsp_last
);
	logic [7:0] got[$];
	logic lasts[$];
	initial begin
		cmd_valid = 1'b0;
		cmd_byte = 8'h00;
		cmd_first = 1'b0;
	end
	always @(posedge ref_clk) begin
		if (rsp_valid === 1'b1) begin
			got.push_back(rsp_byte);
			lasts.push_back(rsp_last);
		end
	end
	// opcode, then padding or the length byte
	task automatic send(input logic [7:0] op, input int n_pad, input logic [7:0] pad);
		@(posedge ref_clk);
		#1;
		for (int i = 0; i <= n_pad; i++) begin
			cmd_valid <= 1'b1;
			cmd_byte <= (i == 0) ? op : pad;
			cmd_first <= (i == 0);
			@(posedge ref_clk);
			#1;
		end
		cmd_valid = 1'b0;
		// released byte lane is inverted once so a stale value cannot pass
		cmd_byte = ~cmd_byte;
		repeat (12) @(posedge ref_clk);
	endtask : send
endmodule : host_model
`default_nettype wire

// ---- testbench/tb_rx_status_query_responder.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_rx_status_query_responder;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic uart_mode, reg_rd, implicit_header, sync_detect, rsp_valid, rsp_last, cmd_valid, cmd_first;
	logic [7:0] chip_status, implicit_size, last_received_size, rx_base_addr, first_byte_offset, live_power;
	logic [7:0] cmd_byte, rsp_byte, reg_rdata, packet_transfer_flags, packet_error_flags, len, err, xf, sy;
	logic [11:0] reg_addr;
	status_query_pkg::packet_type_t packet_type;
	status_query_pkg::engine_status_t eng;
	int mismatches = 0;
	int n_tests = 0;
	logic [7:0] exp_q[$];
	always #5 ref_clk = ~ref_clk;
	rx_status_query_responder u_dut (.*);
	host_model u_host (.*);
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_tests++;
		if (seen !== want) begin
			mismatches++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic wrap_up;
		if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	task automatic query(input logic [7:0] op, input int n, input logic [7:0] pad);
		u_host.got.delete();
		u_host.lasts.delete();
		u_host.send(op, n, pad);
		check(8'(u_host.got.size()), 8'(exp_q.size()));
		foreach (exp_q[i]) begin
			check(u_host.got[i], exp_q[i]);
			check({7'h00, u_host.lasts[i]}, {7'h00, i == exp_q.size() - 1});
		end
	endtask : query
	initial begin
		{uart_mode, reg_rd, implicit_header, sync_detect, chip_status, implicit_size, live_power} = '0;
		{last_received_size, rx_base_addr, first_byte_offset, reg_addr, eng} = '0;
		packet_type = status_query_pkg::PKT_FSK;
		void'($urandom(32'h3522));
		repeat (12) @(posedge ref_clk);
		#1 rstn = 1'b1;
		repeat (4) @(posedge ref_clk);
		for (int k = 0; k < 16; k++) begin
			#1 {chip_status, implicit_size, last_received_size, rx_base_addr} = $urandom;
			eng = 28'($urandom);
			first_byte_offset = 8'($urandom);
			packet_type = status_query_pkg::packet_type_t'(k[1:0]);
			{implicit_header, uart_mode} = 2'(k >> 2);
			// power taken at sync detect, then the live value moves on
			sync_detect = 1'b1;
			live_power = eng.sync_latched_power;
			@(posedge ref_clk);
			#1 sync_detect = 1'b0;
			live_power = ~live_power;
			reg_rd = 1'b1;
			reg_addr = status_query_pkg::ADDR_IMPLICIT_SIZE;
			repeat (2) @(posedge ref_clk);
			#1 check(reg_rdata, implicit_size);
			reg_rd = 1'b0;
			err = {1'b0, eng[25:19]};
			check(packet_error_flags, err);
			xf = {2'b00, eng[27], 4'h0, eng[26]};
			sy = {5'h00, eng.matched_sync_code};
			check(packet_transfer_flags, xf);
			// ble length excludes the two pdu header bytes, which the host adds itself
			len = (packet_type == status_query_pkg::PKT_CHIRP && implicit_header) ? 8'h00 : last_received_size;
			exp_q.delete();
			if (!uart_mode) exp_q = {chip_status, chip_status};
			exp_q = {exp_q, len, 8'(rx_base_addr + first_byte_offset)};
			query(status_query_pkg::OP_RX_BUFFER_QUERY, 3 - 2 * uart_mode, {6'h00, uart_mode, 1'b0});
			exp_q.delete();
			if (!uart_mode) exp_q = {chip_status, chip_status};
			// power correction from a non-positive snr is left to the host
			if (k[1:0] == 2'b11) exp_q = {exp_q, eng.sync_latched_power, eng.snr_quarter_db};
			else exp_q = {exp_q, 8'h00, eng.sync_latched_power, err, xf, sy};
			query(status_query_pkg::OP_PACKET_INFO_QUERY, uart_mode ? 1 : 6, {5'h00, uart_mode, 1'b0, uart_mode});
		end
		wrap_up();
	end
	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end
endmodule : tb_rx_status_query_responder
`default_nettype wire
